// ---- rtl/bcl_cond.sv ----
`timescale 1ns/1ps
`include "bcl_defines.svh"
module bcl_cond (
  bcl_cond_if.cond cif
);

  wire z = cif.flags.zero;
  wire n = cif.flags.negative;
  wire c = cif.flags.carry;
  wire v = cif.flags.overflow;
  wire trap = cif.flags.overflow_trap_flag;
  wire stick = cif.flags.persistent_round_bit;

  ////////////////////////////////////////////////////////////////////////////
  // flags are only read here; only the trap flag is ever cleared
  always_comb begin
    cif.is_branch = 1'b1;
    cif.take = 1'b0;
    cif.clr_trap = 1'b0;
    case (cif.opcode)
      `BCL_OP_SIGNED_GREATER: cif.take = !n && !z;
      `BCL_OP_UNSIGNED_ABOVE: cif.take = c && !z;
      `BCL_OP_SIGNED_AT_MOST: cif.take = n || z;
      `BCL_OP_SIGNED_BELOW: cif.take = n;
      `BCL_OP_CARRY_CLEAR: cif.take = !c;
      `BCL_OP_UNEQUAL: cif.take = !z;
      `BCL_OP_NOT_ABOVE: cif.take = !c || z;
      `BCL_OP_STICKY_CLEAR: cif.take = !stick;
      `BCL_OP_OVERFLOW_CLEAR: cif.take = !v;
      `BCL_OP_TRAP_CLEAR: begin
        cif.take = !trap;
        cif.clr_trap = trap;
      end
      `BCL_OP_STICKY_SET: cif.take = stick;
      `BCL_OP_OVERFLOW_SET: cif.take = v;
      `BCL_OP_TRAP_SET: begin
        cif.take = trap;
        cif.clr_trap = trap;
      end
      default: cif.is_branch = 1'b0;
    endcase
  end

endmodule // bcl_cond

// ---- rtl/bcl_cond_if.sv ----
`timescale 1ns/1ps
interface bcl_cond_if;
  logic [7:0] opcode;
  bcl_pkg::bcl_flags_t flags;
  logic is_branch;
  logic take;
  logic clr_trap;
  modport dec (output opcode, output flags, input is_branch, input take, input clr_trap);
  modport cond (input opcode, input flags, output is_branch, output take, output clr_trap);
endinterface

// ---- rtl/bcl_decode.sv ----
// Summary of operation
// - signed greater: branch when N and Z clear
// - unsigned above: branch when C set, Z clear
// - signed at most: branch when N or Z
// - signed below: branch when N set
// - carry clear: branch when C is zero
// - unequal: branch when Z is clear
// - not above: branch when C clear or Z
// - sticky clear: branch when sticky bit zero
// - overflow clear: branch when V is zero
// - trap clear: branch if trap flag zero, else clear
// - sticky set: branch when sticky bit one
// - overflow set: branch when V is one
// - trap set: if trap flag one, clear, branch
// - short displacement byte, sign-extended, after instruction
// - long call pushes return address in the same cycle as it jumps
// - long jump adds 16-bit displacement, low first
// - load word copies source word to destination
// - load byte copies source byte to destination
// - signext load replicates source sign bit high
// - zeroext load forces destination high byte zero
`timescale 1ns/1ps
`include "bcl_defines.svh"
module bcl_decode (
  input wire logic clock,
  input wire logic reset,
  input wire logic fetch_valid,
  input wire logic [7:0] fetch_byte,
  output logic fetch_req,
  output logic [15:0] pc,
  output logic pc_load,
  input wire logic flag_zero,
  input wire logic flag_negative,
  input wire logic flag_carry,
  input wire logic flag_overflow,
  input wire logic overflow_trap_flag,
  input wire logic persistent_round_bit,
  output logic trap_clear,
  input wire logic [15:0] sp_in,
  output logic sp_write,
  output logic [15:0] sp_value,
  output logic mem_req,
  output logic mem_we,
  output logic mem_word,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  output logic bad_opcode
);

  bcl_pkg::bcl_state_t state_ff, nxt_state;
  logic [15:0] pc_ff, nxt_pc;
  logic [7:0] opc_ff, nxt_opc;
  logic [7:0] disp_lo_ff, nxt_disp_lo;
  logic [15:0] src_ff, nxt_src;
  logic [15:0] ofs_ff, nxt_ofs;
  logic fetch_req_ff, nxt_fetch_req;
  logic pc_load_ff, nxt_pc_load;
  logic trap_clear_ff, nxt_trap_clear;
  logic sp_write_ff, nxt_sp_write;
  logic [15:0] sp_value_ff, nxt_sp_value;
  logic mem_req_ff, nxt_mem_req;
  logic mem_we_ff, nxt_mem_we;
  logic mem_word_ff, nxt_mem_word;
  logic [15:0] mem_addr_ff, nxt_mem_addr;
  logic [15:0] mem_wdata_ff, nxt_mem_wdata;
  logic bad_opcode_ff, nxt_bad_opcode;

  bcl_cond_if cif ();

  bcl_cond u_cond (
    .cif(cif.cond)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode wires

  wire take_byte = fetch_req_ff && fetch_valid;
  wire mem_done = mem_req_ff && mem_ack;
  wire in_opcode = (state_ff == bcl_pkg::S_OPCODE);
  wire [15:0] pc_next = pc_ff + `BCL_PC_STEP;
  wire [15:0] short_disp = {{8{fetch_byte[`BCL_BYTE_SIGN_BIT]}}, fetch_byte};
  wire [15:0] short_target = pc_next + short_disp;
  wire [15:0] long_target = pc_next + {fetch_byte, disp_lo_ff};
  wire [15:0] sp_dec = sp_in - `BCL_SP_STEP;
  wire [15:0] byte_addr = {8'h00, fetch_byte};
  wire [15:0] word_reg_addr = {8'h00, fetch_byte & `BCL_WORD_ALIGN};

  // opcode of the instruction in flight; raw fetch byte throughout the opcode state
  wire [7:0] cur_opc = in_opcode ? fetch_byte : opc_ff;
  wire [5:0] load_pre = cur_opc[7:2];
  wire [1:0] src_mode = cur_opc[1:0];
  wire is_load_word = (load_pre == `BCL_PRE_LOAD_WORD);
  wire is_load_byte = (load_pre == `BCL_PRE_LOAD_BYTE);
  wire is_load_sext = (load_pre == `BCL_PRE_LOAD_SIGNEXT);
  wire is_load_zext = (load_pre == `BCL_PRE_LOAD_ZEROEXT);
  wire is_load = is_load_word || is_load_byte || is_load_sext || is_load_zext;
  wire is_call = (cur_opc == `BCL_OP_LONG_CALL);
  wire is_jump = (cur_opc == `BCL_OP_LONG_JUMP);
  wire is_long = is_call || is_jump;
  // only the byte load writes a byte; the extending loads write a word
  wire dest_is_word = is_load_word || is_load_sext || is_load_zext;

  // result word placed in the destination
  wire [15:0] sext_data = {{8{src_ff[`BCL_BYTE_SIGN_BIT]}}, src_ff[7:0]};
  wire [15:0] zext_data = {8'h00, src_ff[7:0]};
  wire [15:0] load_data = is_load_word ? src_ff :
                          is_load_sext ? sext_data :
                          zext_data;
  wire [15:0] read_data = is_load_word ? mem_rdata : {8'h00, mem_rdata[7:0]};

  // flags are sampled live; the core keeps them steady across a branch
  assign cif.opcode = cur_opc;
  assign cif.flags = '{zero: flag_zero, negative: flag_negative, carry: flag_carry,
                       overflow: flag_overflow, overflow_trap_flag: overflow_trap_flag,
                       persistent_round_bit: persistent_round_bit};

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    nxt_state = state_ff;
    nxt_pc = pc_ff;
    nxt_opc = opc_ff;
    nxt_disp_lo = disp_lo_ff;
    nxt_src = src_ff;
    nxt_ofs = ofs_ff;
    nxt_pc_load = 1'b0;
    nxt_trap_clear = 1'b0;
    nxt_sp_write = 1'b0;
    nxt_sp_value = sp_value_ff;
    nxt_mem_req = mem_req_ff && !mem_ack;
    nxt_mem_we = mem_we_ff;
    nxt_mem_word = mem_word_ff;
    nxt_mem_addr = mem_addr_ff;
    nxt_mem_wdata = mem_wdata_ff;
    nxt_bad_opcode = 1'b0;
    if (take_byte) begin
      nxt_pc = pc_next;
    end
    case (state_ff)
      bcl_pkg::S_OPCODE: begin
        if (take_byte) begin
          nxt_opc = fetch_byte;
          if (cif.is_branch || is_long) begin
            nxt_state = bcl_pkg::S_DISP_LO;
          end else if (is_load) begin
            nxt_state = bcl_pkg::S_SOURCE;
          end else begin
            // foreign opcodes belong to other decode slices
            nxt_bad_opcode = 1'b1;
          end
        end
      end
      bcl_pkg::S_DISP_LO: begin
        if (take_byte) begin
          nxt_disp_lo = fetch_byte;
          if (is_long) begin
            nxt_state = bcl_pkg::S_DISP_HI;
          end else begin
            if (cif.take) begin
              nxt_pc = short_target;
              nxt_pc_load = 1'b1;
            end
            nxt_trap_clear = cif.clr_trap;
            nxt_state = bcl_pkg::S_OPCODE;
          end
        end
      end
      bcl_pkg::S_DISP_HI: begin
        if (take_byte) begin
          nxt_pc = long_target;
          nxt_pc_load = 1'b1;
          nxt_state = bcl_pkg::S_OPCODE;
          if (is_call) begin
            nxt_sp_write = 1'b1;
            nxt_sp_value = sp_dec;
            nxt_mem_req = 1'b1;
            nxt_mem_we = 1'b1;
            nxt_mem_word = 1'b1;
            nxt_mem_addr = sp_dec;
            nxt_mem_wdata = pc_next;
            nxt_state = bcl_pkg::S_PUSH;
          end
        end
      end
      bcl_pkg::S_SOURCE: begin
        if (take_byte) begin
          nxt_ofs = 16'h0000;
          nxt_mem_we = 1'b0;
          nxt_mem_word = 1'b1;
          case (src_mode)
            `BCL_MODE_DIRECT: begin
              nxt_mem_req = 1'b1;
              nxt_mem_word = is_load_word;
              nxt_mem_addr = byte_addr;
              nxt_state = bcl_pkg::S_DATA_READ;
            end
            `BCL_MODE_IMMEDIATE: begin
              nxt_src = {8'h00, fetch_byte};
              nxt_state = is_load_word ? bcl_pkg::S_IMM_HI : bcl_pkg::S_DEST;
            end
            `BCL_MODE_INDIRECT: begin
              nxt_mem_req = 1'b1;
              nxt_mem_addr = word_reg_addr;
              nxt_state = bcl_pkg::S_PTR_READ;
            end
            default: begin
              // indexed: the low address bit marks a long offset
              nxt_mem_addr = word_reg_addr;
              nxt_src = {15'h0000, fetch_byte[`BCL_LONG_INDEX_BIT]};
              nxt_state = bcl_pkg::S_OFS_LO;
            end
          endcase
        end
      end
      bcl_pkg::S_IMM_HI: begin
        if (take_byte) begin
          nxt_src = {fetch_byte, src_ff[7:0]};
          nxt_state = bcl_pkg::S_DEST;
        end
      end
      bcl_pkg::S_OFS_LO: begin
        if (take_byte) begin
          if (src_ff[`BCL_LONG_INDEX_BIT]) begin
            nxt_ofs = {8'h00, fetch_byte};
            nxt_state = bcl_pkg::S_OFS_HI;
          end else begin
            nxt_ofs = short_disp;
            nxt_mem_req = 1'b1;
            nxt_state = bcl_pkg::S_PTR_READ;
          end
        end
      end
      bcl_pkg::S_OFS_HI: begin
        if (take_byte) begin
          nxt_ofs = {fetch_byte, ofs_ff[7:0]};
          nxt_mem_req = 1'b1;
          nxt_state = bcl_pkg::S_PTR_READ;
        end
      end
      bcl_pkg::S_PTR_READ: begin
        if (mem_done) begin
          nxt_mem_req = 1'b1;
          nxt_mem_word = is_load_word;
          nxt_mem_addr = mem_rdata + ofs_ff;
          nxt_state = bcl_pkg::S_DATA_READ;
        end
      end
      bcl_pkg::S_DATA_READ: begin
        if (mem_done) begin
          nxt_src = read_data;
          nxt_state = bcl_pkg::S_DEST;
        end
      end
      bcl_pkg::S_DEST: begin
        if (take_byte) begin
          nxt_mem_req = 1'b1;
          nxt_mem_we = 1'b1;
          nxt_mem_word = dest_is_word;
          nxt_mem_addr = byte_addr;
          nxt_mem_wdata = load_data;
          nxt_state = bcl_pkg::S_WRITE;
        end
      end
      bcl_pkg::S_WRITE, bcl_pkg::S_PUSH: begin
        if (mem_done) begin
          nxt_state = bcl_pkg::S_OPCODE;
        end
      end
      default: nxt_state = bcl_pkg::S_OPCODE;
    endcase
    // byte wanted next cycle; never while a memory access is open
    nxt_fetch_req = (nxt_state == bcl_pkg::S_OPCODE || nxt_state == bcl_pkg::S_DISP_LO ||
                     nxt_state == bcl_pkg::S_DISP_HI || nxt_state == bcl_pkg::S_SOURCE ||
                     nxt_state == bcl_pkg::S_IMM_HI || nxt_state == bcl_pkg::S_OFS_LO ||
                     nxt_state == bcl_pkg::S_OFS_HI || nxt_state == bcl_pkg::S_DEST);
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clock) begin
    if (reset) begin
      state_ff <= bcl_pkg::S_OPCODE;
      pc_ff <= `BCL_PC_RESET;
      fetch_req_ff <= 1'b0;
      pc_load_ff <= 1'b0;
      trap_clear_ff <= 1'b0;
      sp_write_ff <= 1'b0;
      mem_req_ff <= 1'b0;
      bad_opcode_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pc_ff <= nxt_pc;
      fetch_req_ff <= nxt_fetch_req;
      pc_load_ff <= nxt_pc_load;
      trap_clear_ff <= nxt_trap_clear;
      sp_write_ff <= nxt_sp_write;
      mem_req_ff <= nxt_mem_req;
      bad_opcode_ff <= nxt_bad_opcode;
    end
  end

  // datapath holds; reset value only matters for a clean first view
  always_ff @(posedge clock) begin
    if (reset) begin
      opc_ff <= 8'h00;
      disp_lo_ff <= 8'h00;
      src_ff <= 16'h0000;
      ofs_ff <= 16'h0000;
      sp_value_ff <= 16'h0000;
      mem_we_ff <= 1'b0;
      mem_word_ff <= 1'b0;
      mem_addr_ff <= 16'h0000;
      mem_wdata_ff <= 16'h0000;
    end else begin
      opc_ff <= nxt_opc;
      disp_lo_ff <= nxt_disp_lo;
      src_ff <= nxt_src;
      ofs_ff <= nxt_ofs;
      sp_value_ff <= nxt_sp_value;
      mem_we_ff <= nxt_mem_we;
      mem_word_ff <= nxt_mem_word;
      mem_addr_ff <= nxt_mem_addr;
      mem_wdata_ff <= nxt_mem_wdata;
    end
  end

  assign fetch_req = fetch_req_ff;
  assign pc = pc_ff;
  assign pc_load = pc_load_ff;
  assign trap_clear = trap_clear_ff;
  assign sp_write = sp_write_ff;
  assign sp_value = sp_value_ff;
  assign mem_req = mem_req_ff;
  assign mem_we = mem_we_ff;
  assign mem_word = mem_word_ff;
  assign mem_addr = mem_addr_ff;
  assign mem_wdata = mem_wdata_ff;
  assign bad_opcode = bad_opcode_ff;

endmodule // bcl_decode

// ---- rtl/bcl_defines.svh ----
`ifndef BCL_DEFINES_SVH
`define BCL_DEFINES_SVH

// short conditional branch opcodes
`define BCL_OP_SIGNED_GREATER 8'hD2
`define BCL_OP_UNSIGNED_ABOVE 8'hD9
`define BCL_OP_SIGNED_AT_MOST 8'hDA
`define BCL_OP_SIGNED_BELOW 8'hDE
`define BCL_OP_CARRY_CLEAR 8'hD3
`define BCL_OP_UNEQUAL 8'hD7
`define BCL_OP_NOT_ABOVE 8'hD1
`define BCL_OP_STICKY_CLEAR 8'hD0
`define BCL_OP_OVERFLOW_CLEAR 8'hD5
`define BCL_OP_TRAP_CLEAR 8'hD4
`define BCL_OP_STICKY_SET 8'hD8
`define BCL_OP_OVERFLOW_SET 8'hDD
`define BCL_OP_TRAP_SET 8'hDC

// long transfers
`define BCL_OP_LONG_CALL 8'hEF
`define BCL_OP_LONG_JUMP 8'hE7

// load opcode prefixes, upper six bits; low two bits pick the mode
`define BCL_PRE_LOAD_WORD 6'h28
`define BCL_PRE_LOAD_BYTE 6'h2C
`define BCL_PRE_LOAD_SIGNEXT 6'h2F
`define BCL_PRE_LOAD_ZEROEXT 6'h2B

// source addressing modes
`define BCL_MODE_DIRECT 2'h0
`define BCL_MODE_IMMEDIATE 2'h1
`define BCL_MODE_INDIRECT 2'h2
`define BCL_MODE_INDEXED 2'h3

`define BCL_PC_RESET 16'h0000
`define BCL_PC_STEP 16'h0001
`define BCL_SP_STEP 16'h0002
`define BCL_WORD_ALIGN 8'hFE
`define BCL_LONG_INDEX_BIT 0
`define BCL_BYTE_SIGN_BIT 7

`endif

// ---- rtl/bcl_pkg.sv ----
package bcl_pkg;

  typedef enum logic [3:0] {
    S_OPCODE = 4'h0,
    S_DISP_LO = 4'h1,
    S_DISP_HI = 4'h2,
    S_SOURCE = 4'h3,
    S_IMM_HI = 4'h4,
    S_OFS_LO = 4'h5,
    S_OFS_HI = 4'h6,
    S_PTR_READ = 4'h7,
    S_DATA_READ = 4'h8,
    S_DEST = 4'h9,
    S_WRITE = 4'hA,
    S_PUSH = 4'hB
  } bcl_state_t;

  typedef struct packed {
    logic zero;
    logic negative;
    logic carry;
    logic overflow;
    logic overflow_trap_flag;
    logic persistent_round_bit;
  } bcl_flags_t;

endpackage

// ---- testbench/bcl_decode_checker.sv ----
`timescale 1ns/1ps
module bcl_decode_checker (
  input wire logic clock,
  input wire logic reset,
  input wire logic fetch_valid,
  input wire logic fetch_req,
  input wire logic [15:0] pc,
  input wire logic pc_load,
  input wire logic trap_clear,
  input wire logic [15:0] sp_in,
  input wire logic sp_write,
  input wire logic [15:0] sp_value,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_word,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic bad_opcode
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  sequence s_mem_wait;
    mem_req && !mem_ack;
  endsequence
  sequence s_write_done;
    mem_req && mem_ack && mem_we;
  endsequence
  sequence s_push;
    pc_load && mem_req && mem_we && mem_word && mem_addr == sp_value;
  endsequence
  ////////////////////////////////////////
  a_reset_quiet: assert property (disable iff (1'b0)
    reset |=> !fetch_req && !mem_req && !pc_load && !sp_write && pc == 16'h0000)
    else $error("outputs not idle after reset");
  a_call_push: assert property (sp_write |-> s_push)
    else $error("call push not paired with jump");
  a_sp_value: assert property (sp_write |-> sp_value == $past(sp_in) - 16'h0002)
    else $error("stack pointer not lowered by two");
  a_mem_hold: assert property (s_mem_wait |=> mem_req && $stable(mem_addr)
    && $stable(mem_we) && $stable(mem_word) && $stable(mem_wdata))
    else $error("memory request changed before ack");
  a_mem_stall: assert property (s_mem_wait |-> !fetch_req)
    else $error("fetch during memory access");
  a_write_resume: assert property (s_write_done |=> fetch_req)
    else $error("fetch not resumed after write");
  // a redirect is the only way pc may leave its step
  a_pc_step: assert property (fetch_req && fetch_valid |=> pc_load
    || pc == $past(pc) + 16'h0001)
    else $error("pc did not step on fetch");
  a_pc_hold: assert property (!fetch_req |=> pc_load || $stable(pc))
    else $error("pc moved without fetch");
  a_trap_pulse: assert property (trap_clear |=> !trap_clear && !pc_load)
    else $error("trap clear not a single pulse");
  a_bad_skip: assert property (bad_opcode |-> !pc_load && !trap_clear && !mem_req)
    else $error("foreign opcode had effects");
endmodule // bcl_decode_checker

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin err_total++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb;
  logic clock, reset, fetch_valid, fetch_req, pc_load, trap_clear, sp_write;
  logic mem_req, mem_we, mem_word, mem_ack, bad_opcode;
  logic [7:0] fetch_byte;
  logic [5:0] fl;
  logic [15:0] pc, sp_in, sp_value, mem_addr, mem_wdata, mem_rdata, a;
  logic [7:0] prog [0:255];
  int err_total, checks_done;
  localparam logic [7:0] OPS [13] = '{8'hD2, 8'hD9, 8'hDA, 8'hDE, 8'hD3, 8'hD7,
    8'hD1, 8'hD0, 8'hD5, 8'hD4, 8'hD8, 8'hDD, 8'hDC};
  localparam logic [7:0] IOP [5] = '{8'hA1, 8'hB1, 8'hBD, 8'hBD, 8'hAD};
  localparam logic [7:0] IVAL [5] = '{8'h34, 8'hC3, 8'h85, 8'h7A, 8'h85};

  bcl_decode bcl_decode_inst (.clock, .reset, .fetch_valid, .fetch_byte, .fetch_req, .pc,
    .pc_load, .flag_zero(fl[5]), .flag_negative(fl[4]), .flag_carry(fl[3]),
    .flag_overflow(fl[2]), .overflow_trap_flag(fl[1]), .persistent_round_bit(fl[0]),
    .trap_clear, .sp_in, .sp_write, .sp_value, .mem_req, .mem_we, .mem_word, .mem_addr,
    .mem_wdata, .mem_rdata, .mem_ack, .bad_opcode);
  ////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // fetch port follows pc; filler 8'hFD is outside the slice
  always @(posedge clock) #1 fetch_byte <= prog[pc[7:0]];

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // bytes land two ahead of pc, before the fetch port reaches them
  task automatic put(input logic [7:0] b0, b1, b2, b3);
    step(1);
    a = pc + 16'h0002;
    prog[a[7:0]] = b0;
    prog[a[7:0] + 8'h01] = b1;
    prog[a[7:0] + 8'h02] = b2;
    prog[a[7:0] + 8'h03] = b3;
  endtask
  task automatic clr;
    for (int k = 0; k < 4; k++) prog[a[7:0] + k[7:0]] = 8'hFD;
  endtask
  task automatic mem(input logic we, wd, input logic [15:0] ad, dt, rd);
    int k;
    k = 0;
    while (mem_req !== 1'b1 && k < 20) begin
      step(1);
      k++;
    end
    `CHK("mem_req", 1'b1, mem_req)
    `CHK("mem_we", we, mem_we)
    `CHK("mem_word", wd, mem_word)
    `CHK("mem_addr", ad, mem_addr)
    `CHK("fetch_req", 1'b0, fetch_req)
    if (we) `CHK("mem_wdata", wd ? dt : {8'h00, dt[7:0]},
      wd ? mem_wdata : {8'h00, mem_wdata[7:0]})
    step(2);
    mem_ack = 1'b1;
    mem_rdata = rd;
    step(1);
    mem_ack = 1'b0;
    mem_rdata = ~rd;
  endtask
  function automatic logic take(input logic [7:0] op, input logic [5:0] f);
    logic z, n, c, v, trap, stick;
    {z, n, c, v, trap, stick} = f;
    case (op)
      8'hD2: take = !n && !z;
      8'hD9: take = c && !z;
      8'hDA: take = n || z;
      8'hDE: take = n;
      8'hD3: take = !c;
      8'hD7: take = !z;
      8'hD1: take = !c || z;
      8'hD0: take = !stick;
      8'hD5: take = !v;
      8'hD4: take = !trap;
      8'hD8: take = stick;
      8'hDD: take = v;
      default: take = trap;
    endcase
  endfunction
  ////////////////////////////////////////
  task automatic t_branch;
    logic [7:0] op, d;
    logic tk, tc;
    logic [15:0] ex;
    for (int i = 0; i < 13; i++) begin
      for (int f = 0; f < 64; f++) begin
        op = OPS[i];
        d = (f[0] ^ i[0]) ? 8'h80 : 8'h7F;
        fl = f[5:0];
        put(op, d, 8'hFD, 8'hFD);
        tk = take(op, f[5:0]);
        tc = f[1] && (op == 8'hD4 || op == 8'hDC);
        // pulses stand one cycle only, right after the displacement is taken
        ex = tk ? a + 16'h0002 + {{8{d[7]}}, d} : a + 16'h0002;
        step(4);
        `CHK("pc_load", tk, pc_load)
        `CHK("trap_clear", tc, trap_clear)
        `CHK("pc", ex, pc)
        clr;
      end
    end
  endtask
  task automatic t_long(input logic [7:0] op, input logic [15:0] d);
    logic [15:0] ra;
    put(op, d[7:0], d[15:8], 8'hFD);
    ra = a + 16'h0003;
    step(5);
    `CHK("pc", ra + d, pc)
    `CHK("pc_load", 1'b1, pc_load)
    `CHK("trap_clear", 1'b0, trap_clear)
    `CHK("sp_write", op == 8'hEF, sp_write)
    if (op == 8'hEF) begin
      `CHK("sp_value", sp_in - 16'h0002, sp_value)
      mem(1'b1, 1'b1, sp_in - 16'h0002, ra, 16'h0000);
    end
    clr;
  endtask
  task automatic t_load_direct;
    put(8'hA0, 8'h34, 8'h56, 8'hFD);
    mem(1'b0, 1'b1, 16'h0034, 16'h0000, 16'hBEEF);
    mem(1'b1, 1'b1, 16'h0056, 16'hBEEF, 16'h0000);
    clr;
    put(8'hBC, 8'h40, 8'h42, 8'hFD);
    mem(1'b0, 1'b0, 16'h0040, 16'h0000, 16'h12F0);
    mem(1'b1, 1'b1, 16'h0042, 16'hFFF0, 16'h0000);
    clr;
  endtask
  task automatic t_load_imm;
    logic [7:0] op, v;
    logic [15:0] ex;
    for (int i = 0; i < 5; i++) begin
      op = IOP[i];
      v = IVAL[i];
      if (op[7:2] == 6'h28) put(op, v, 8'h92, 8'h60);
      else put(op, v, 8'h60, 8'hFD);
      case (op[7:2])
        6'h28: ex = {8'h92, v};
        6'h2F: ex = {{8{v[7]}}, v};
        default: ex = {8'h00, v};
      endcase
      mem(1'b1, op[7:2] != 6'h2C, 16'h0060, ex, 16'h0000);
      clr;
    end
  endtask
  task automatic t_load_ptr;
    put(8'hA2, 8'h21, 8'h44, 8'hFD);
    mem(1'b0, 1'b1, 16'h0020, 16'h0000, 16'h1234);
    mem(1'b0, 1'b1, 16'h1234, 16'h0000, 16'h0F0F);
    mem(1'b1, 1'b1, 16'h0044, 16'h0F0F, 16'h0000);
    clr;
    put(8'hA3, 8'h30, 8'hFE, 8'h46);
    mem(1'b0, 1'b1, 16'h0030, 16'h0000, 16'h2000);
    mem(1'b0, 1'b1, 16'h1FFE, 16'h0000, 16'h5566);
    mem(1'b1, 1'b1, 16'h0046, 16'h5566, 16'h0000);
    clr;
    // long index offset; dest byte is the filler after the four bytes
    put(8'hA3, 8'h31, 8'h10, 8'h01);
    mem(1'b0, 1'b1, 16'h0030, 16'h0000, 16'h2000);
    mem(1'b0, 1'b1, 16'h2110, 16'h0000, 16'h7788);
    mem(1'b1, 1'b1, 16'h00FD, 16'h7788, 16'h0000);
    clr;
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    #300000;
    err_total++;
    stop_test;
  end
  initial begin
    err_total = 0;
    checks_done = 0;
    reset = 1'b1;
    fetch_valid = 1'b1;
    fl = 6'h00;
    sp_in = 16'h0100;
    mem_ack = 1'b0;
    mem_rdata = 16'hFFFF;
    for (int k = 0; k < 256; k++) prog[k] = 8'hFD;
    step(3);
    reset = 1'b0;
    step(3);
    `CHK("bad_opcode", 1'b1, bad_opcode)
    t_branch;
    t_long(8'hE7, 16'h8000);
    t_long(8'hE7, 16'h7FFF);
    t_long(8'hEF, 16'h7FFF);
    sp_in = 16'h0000;
    t_long(8'hEF, 16'h8000);
    t_load_direct;
    t_load_imm;
    t_load_ptr;
    step(4);
    stop_test;
  end
endmodule // tb

bind bcl_decode bcl_decode_checker bcl_decode_checker_inst (.clock, .reset, .fetch_valid,
  .fetch_req, .pc, .pc_load, .trap_clear, .sp_in, .sp_write, .sp_value, .mem_req, .mem_we,
  .mem_word, .mem_addr, .mem_wdata, .mem_ack, .bad_opcode);
